// ---- rtl/dcw_pkg.sv ----
package dcw_pkg;

    // serial programming port framing
    localparam int DCW_INSTR_BITS = 8;
    localparam int DCW_DATA_BITS = 32;
    localparam int DCW_ADDR_BITS = 5;
    localparam int DCW_RD_FLAG_POS = 7;
    localparam logic [4:0] DCW_CTRL_ONE_ADDR = 5'h00;
    localparam logic [31:0] DCW_CTRL_ONE_RESET = 32'h0000_0000;
    localparam logic [2:0] DCW_PROFILE_RESET = 3'h0;

    // sync clock runs at the core clock divided by twice this count
    localparam int DCW_SYNC_HALF_DEFAULT = 2;

    // layout of control_function_one, msb first
    typedef struct packed {
        logic [2:0] open_hi;
        logic mod_en;
        logic use_int_profile;
        logic pipe_unmatched;
        logic [1:0] open_mid;
        logic lsb_first;
        logic [2:0] int_profile;
        logic sync_clk_dis;
        logic [1:0] open_lo;
        logic direct_switch_en;
        logic clr_aux_acc;
        logic clr_phase_acc;
        logic [13:0] lower;
    } dcw_ctrl_one_t;

    // one completed serial write
    typedef struct packed {
        logic stb;
        logic [DCW_ADDR_BITS-1:0] addr;
        logic [DCW_DATA_BITS-1:0] data;
    } dcw_wr_t;

endpackage : dcw_pkg

// ---- rtl/dcw_sport.sv ----
module dcw_sport
    import dcw_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdio_in,
    input wire logic lsb_first_in,
    input wire logic [DCW_DATA_BITS-1:0] rd_data_in,
    output dcw_wr_t wr_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    localparam logic [5:0] LAST_BIT = 6'(DCW_INSTR_BITS + DCW_DATA_BITS - 1);
    localparam logic [5:0] LAST_INSTR = 6'(DCW_INSTR_BITS - 1);

    logic sclk_d_r;
    logic [5:0] cnt_r;
    logic [7:0] instr_r;
    logic [DCW_DATA_BITS-1:0] shift_r;
    logic [DCW_DATA_BITS-1:0] rd_word_r;
    logic load_rd_r;
    logic sdo_r;
    logic oe_r;
    dcw_wr_t wr_r;

    wire sclk_rise = sclk_in & ~sclk_d_r & ~cs_n_in;
    wire sclk_fall = ~sclk_in & sclk_d_r & ~cs_n_in;
    wire in_data = cnt_r > LAST_INSTR;
    wire is_read = instr_r[DCW_RD_FLAG_POS];
    wire [7:0] instr_nxt = lsb_first_in ? {sdio_in, instr_r[7:1]} : {instr_r[6:0], sdio_in};
    wire [DCW_DATA_BITS-1:0] shift_nxt = lsb_first_in ? {sdio_in, shift_r[DCW_DATA_BITS-1:1]}
                                                       : {shift_r[DCW_DATA_BITS-2:0], sdio_in};
    wire [4:0] bit_idx = 5'(cnt_r - 6'(DCW_INSTR_BITS));
    wire sdo_nxt = lsb_first_in ? rd_word_r[bit_idx] : rd_word_r[5'd31 - bit_idx];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_d_r <= 1'b0;
            cnt_r <= 6'h00;
            instr_r <= 8'h00;
            shift_r <= '0;
            rd_word_r <= '0;
            load_rd_r <= 1'b0;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
            wr_r <= '0;
        end else begin
            sclk_d_r <= sclk_in;
            wr_r.stb <= 1'b0;
            load_rd_r <= 1'b0;
            if (load_rd_r) begin
                rd_word_r <= rd_data_in;
            end
            if (cs_n_in) begin
                // deselect aborts a partial frame
                cnt_r <= 6'h00;
                oe_r <= 1'b0;
            end else if (sclk_rise) begin
                if (!in_data) begin
                    instr_r <= instr_nxt;
                end else begin
                    shift_r <= shift_nxt;
                end
                load_rd_r <= cnt_r == LAST_INSTR;
                cnt_r <= (cnt_r == LAST_BIT) ? 6'h00 : cnt_r + 6'h01;
                if (cnt_r == LAST_BIT) begin
                    wr_r.stb <= ~is_read;
                    wr_r.addr <= instr_r[DCW_ADDR_BITS-1:0];
                    wr_r.data <= shift_nxt;
                    oe_r <= 1'b0;
                end
            end else if (sclk_fall && in_data && is_read) begin
                sdo_r <= sdo_nxt;
                oe_r <= 1'b1;
            end
        end
    end

    assign wr_out = wr_r;
    assign sdo_out = sdo_r;
    assign sdo_oe_out = oe_r;

endmodule : dcw_sport

// ---- rtl/dcw_ctrl_word.sv ----
module dcw_ctrl_word
    import dcw_pkg::*;
#(
    parameter int SYNC_HALF = DCW_SYNC_HALF_DEFAULT
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic SCLK_IN,
    input wire logic CS_N_IN,
    input wire logic SDIO_IN,
    input wire logic IO_UPDATE_IN,
    input wire logic [2:0] PROFILE_PINS_IN,
    input wire logic LINEAR_SWEEP_EN_IN,
    output logic SDIO_OUT,
    output logic SDIO_OE_OUT,
    output logic SYNC_CLK_OUT,
    output logic SYNC_CLK_OE_OUT,
    output logic AUX_SWEEP_OUT,
    output logic AUX_MODULUS_OUT,
    output logic [2:0] PROFILE_SEL_OUT,
    output logic PIPE_MATCH_OUT,
    output logic DIRECT_SWITCH_OUT,
    output logic AUX_ACC_CLR_OUT,
    output logic PHASE_ACC_CLR_OUT
);
    dcw_ctrl_one_t staged_r;
    dcw_ctrl_one_t active_r;
    dcw_wr_t wr;
    logic [DCW_DATA_BITS-1:0] rd_data;
    logic io_upd_d_r;
    logic [7:0] sync_cnt_r;
    logic sync_lvl_r;
    logic aux_pend_r;
    logic aux_pend_nxt;
    logic sdo;
    logic sdo_oe;
    logic sdo_r;
    logic sdo_oe_r;
    logic sync_out_r;
    logic sync_oe_r;
    logic aux_sweep_r;
    logic aux_mod_r;
    logic [2:0] prof_r;
    logic pipe_match_r;
    logic dsw_r;
    logic aux_clr_r;
    logic phase_clr_r;

    localparam logic [7:0] SYNC_LAST = 8'(SYNC_HALF - 1);

    dcw_sport u_sport (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .sclk_in(SCLK_IN),
        .cs_n_in(CS_N_IN),
        .sdio_in(SDIO_IN),
        .lsb_first_in(active_r.lsb_first),
        .rd_data_in(rd_data),
        .wr_out(wr),
        .sdo_out(sdo),
        .sdo_oe_out(sdo_oe)
    );

    // readback shows the staged copy; other addresses are outside this block
    wire addr_hit = wr.addr == DCW_CTRL_ONE_ADDR;
    assign rd_data = staged_r;
    wire io_upd = IO_UPDATE_IN & ~io_upd_d_r;
    wire sync_rise = (sync_cnt_r == SYNC_LAST) & ~sync_lvl_r;
    wire [2:0] prof_nxt = active_r.use_int_profile ? active_r.int_profile
                                                   : PROFILE_PINS_IN;
    wire prof_chg = prof_nxt != prof_r;

    // a trigger landing on the sync edge waits for the following one
    assign aux_pend_nxt = io_upd | prof_chg | (aux_pend_r & ~sync_rise);

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            staged_r <= DCW_CTRL_ONE_RESET;
            active_r <= DCW_CTRL_ONE_RESET;
            io_upd_d_r <= 1'b0;
        end else begin
            io_upd_d_r <= IO_UPDATE_IN;
            if (wr.stb && addr_hit) begin
                staged_r <= wr.data;
            end
            if (io_upd) begin
                active_r <= staged_r;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync_cnt_r <= 8'h00;
            sync_lvl_r <= 1'b0;
            aux_pend_r <= 1'b0;
        end else begin
            sync_cnt_r <= (sync_cnt_r == SYNC_LAST) ? 8'h00 : sync_cnt_r + 8'h01;
            if (sync_cnt_r == SYNC_LAST) begin
                sync_lvl_r <= ~sync_lvl_r;
            end
            aux_pend_r <= aux_pend_nxt;
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
            sync_out_r <= 1'b0;
            sync_oe_r <= 1'b1;
            aux_sweep_r <= 1'b0;
            aux_mod_r <= 1'b0;
            prof_r <= DCW_PROFILE_RESET;
            pipe_match_r <= 1'b1;
            dsw_r <= 1'b0;
            aux_clr_r <= 1'b0;
            phase_clr_r <= 1'b0;
        end else begin
            sdo_r <= sdo;
            sdo_oe_r <= sdo_oe;
            sync_out_r <= sync_lvl_r & ~active_r.sync_clk_dis;
            sync_oe_r <= ~active_r.sync_clk_dis;
            aux_sweep_r <= LINEAR_SWEEP_EN_IN & ~active_r.mod_en;
            aux_mod_r <= LINEAR_SWEEP_EN_IN & active_r.mod_en;
            prof_r <= prof_nxt;
            pipe_match_r <= ~active_r.pipe_unmatched;
            dsw_r <= active_r.direct_switch_en;
            if (aux_pend_r && sync_rise) begin
                aux_clr_r <= active_r.clr_aux_acc;
            end
            phase_clr_r <= active_r.clr_phase_acc;
        end
    end

    assign SDIO_OUT = sdo_r;
    assign SDIO_OE_OUT = sdo_oe_r;
    assign SYNC_CLK_OUT = sync_out_r;
    assign SYNC_CLK_OE_OUT = sync_oe_r;
    assign AUX_SWEEP_OUT = aux_sweep_r;
    assign AUX_MODULUS_OUT = aux_mod_r;
    assign PROFILE_SEL_OUT = prof_r;
    assign PIPE_MATCH_OUT = pipe_match_r;
    assign DIRECT_SWITCH_OUT = dsw_r;
    assign AUX_ACC_CLR_OUT = aux_clr_r;
    assign PHASE_ACC_CLR_OUT = phase_clr_r;

    a_write_staged: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        wr.stb && addr_hit |=> staged_r == $past(wr.data))
        else $error("write to address zero not staged");

    a_stage_holds: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !io_upd |=> $stable(active_r))
        else $error("active copy changed without update");

    a_update_moves: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        io_upd |=> active_r == $past(staged_r))
        else $error("update did not transfer staged word");

    a_mod_ignored: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !LINEAR_SWEEP_EN_IN |=> !AUX_MODULUS_OUT && !AUX_SWEEP_OUT)
        else $error("aux mode active with sweep off");

    a_aux_mode_sel: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        LINEAR_SWEEP_EN_IN |=> AUX_MODULUS_OUT == $past(active_r.mod_en)
                               && AUX_SWEEP_OUT != AUX_MODULUS_OUT)
        else $error("aux accumulator use wrong");

    a_profile_source: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        1'b1 |=> PROFILE_SEL_OUT == ($past(active_r.use_int_profile)
                 ? $past(active_r.int_profile) : $past(PROFILE_PINS_IN)))
        else $error("profile source wrong");

    a_pipe_match: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        1'b1 |=> PIPE_MATCH_OUT != $past(active_r.pipe_unmatched))
        else $error("pipeline match wrong");

    a_sync_off: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        active_r.sync_clk_dis [*2] |-> !SYNC_CLK_OUT && !SYNC_CLK_OE_OUT)
        else $error("sync clock driven while disabled");

    a_direct_switch: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        1'b1 |=> DIRECT_SWITCH_OUT == $past(active_r.direct_switch_en))
        else $error("direct switch mode wrong");

    a_aux_clr_sync: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !(aux_pend_r && sync_rise) |=> $stable(AUX_ACC_CLR_OUT))
        else $error("aux clear changed off sync edge");

    a_aux_clr_apply: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        aux_pend_r && sync_rise |=> AUX_ACC_CLR_OUT == $past(active_r.clr_aux_acc))
        else $error("aux clear not applied");

    a_phase_clr: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        1'b1 |=> PHASE_ACC_CLR_OUT == $past(active_r.clr_phase_acc))
        else $error("phase clear wrong");

    a_other_addr: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        wr.stb && !addr_hit |=> $stable(staged_r))
        else $error("write to other address staged");

    a_sync_runs: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !active_r.sync_clk_dis |=> SYNC_CLK_OUT == $past(sync_lvl_r) && SYNC_CLK_OE_OUT)
        else $error("sync clock not driven while enabled");

    a_aux_arm: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        io_upd || prof_chg |=> aux_pend_r)
        else $error("aux clear trigger not armed");

    a_aux_clr_steady: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !aux_pend_r |=> $stable(AUX_ACC_CLR_OUT))
        else $error("aux clear moved without trigger");

endmodule : dcw_ctrl_word

// ---- verification/dcw_host.sv ----
module dcw_host (
    input wire logic clk_in,
    input wire logic sdio_w_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdio_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdio_out = 1'b0;
    end

    // one 40-bit frame; each data bit is held six core clocks, the serial clock low for two and high for four
    task automatic frame(input logic [7:0] ins, input logic [31:0] d, input logic lsb,
                         output logic [31:0] q);
        int k;
        q = 32'h0000_0000;
        cs_n_out = 1'b0;
        for (int i = 0; i < 40; i++) begin
            k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
            @(negedge clk_in);
            sclk_out = 1'b0;
            // during readback the host lets go, so its line wanders
            sdio_out = (i < 8) ? ins[k] : (ins[7] ? ~sdio_out : d[k]);
            repeat (2) @(negedge clk_in);
            // read data is taken as the clock rises; the driver drops after the last rise
            if (i >= 8) q[k] = sdio_w_in;
            sclk_out = 1'b1;
            repeat (3) @(negedge clk_in);
        end
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdio_out = ~sdio_out;
        // one idle clock so a following frame never lowers select in this time step
        @(negedge clk_in);
    endtask : frame
endmodule : dcw_host

// ---- verification/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SH = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic io_upd = 1'b0;
    logic sweep = 1'b0;
    logic [2:0] pins = 3'h3;
    logic host_sclk, host_cs_n, host_sdio, sdio_w;
    logic sdio_o, sdio_oe, sync_clk, sync_oe, aux_sw, aux_mod, pipe, dsw, aux_clr, ph_clr;
    logic [2:0] prof;
    logic [8:0] outs;
    logic lsb_mode = 1'b0;
    logic [31:0] act_w = 32'h0000_0000;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;

    always #10 clk = ~clk;
    assign sdio_w = sdio_oe ? sdio_o : host_sdio;
    assign outs = {aux_sw, aux_mod, prof, pipe, dsw, ph_clr, sync_oe};

    dcw_ctrl_word #(.SYNC_HALF(SH)) uut (.SYS_CLK_IN(clk), .RST_IN(rst), .SCLK_IN(host_sclk),
        .CS_N_IN(host_cs_n), .SDIO_IN(sdio_w), .IO_UPDATE_IN(io_upd), .PROFILE_PINS_IN(pins),
        .LINEAR_SWEEP_EN_IN(sweep), .SDIO_OUT(sdio_o), .SDIO_OE_OUT(sdio_oe),
        .SYNC_CLK_OUT(sync_clk), .SYNC_CLK_OE_OUT(sync_oe), .AUX_SWEEP_OUT(aux_sw),
        .AUX_MODULUS_OUT(aux_mod), .PROFILE_SEL_OUT(prof), .PIPE_MATCH_OUT(pipe),
        .DIRECT_SWITCH_OUT(dsw), .AUX_ACC_CLR_OUT(aux_clr), .PHASE_ACC_CLR_OUT(ph_clr));
    dcw_host host (.clk_in(clk), .sdio_w_in(sdio_w), .sclk_out(host_sclk),
        .cs_n_out(host_cs_n), .sdio_out(host_sdio));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [8:0] expo(input logic [31:0] w);
        expo = {sweep & ~w[28], sweep & w[28], w[27] ? w[22:20] : pins, ~w[26], w[16], w[14],
                ~w[19]};
    endfunction : expo

    task automatic final_report;
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic apply(input logic [31:0] w);
        logic [31:0] q;
        host.frame(8'h00, w, lsb_mode, q);
        repeat (3) @(negedge clk);
        chk(32'(outs), 32'(expo(act_w)));
        chk(32'(aux_clr), 32'(act_w[15]));
        host.frame(8'h80, 32'h0000_0000, lsb_mode, q);
        chk(q, w);
        io_upd = 1'b1;
        @(negedge clk);
        io_upd = 1'b0;
        repeat (2) @(negedge clk);
        act_w = w;
        lsb_mode = w[23];
        chk(32'(outs), 32'(expo(w)));
    endtask : apply

    task automatic sync_chk;
        int n;
        logic p;
        n = 0;
        p = sync_clk;
        repeat (16) begin
            @(negedge clk);
            if (sync_clk !== p) n++;
            p = sync_clk;
        end
        chk(32'(n), act_w[19] ? 32'h0000_0000 : 32'(16 / SH));
        chk(32'(sync_clk & act_w[19]), 32'h0000_0000);
    endtask : sync_chk

    task automatic t_reset;
        logic [31:0] q;
        chk(32'(outs), 32'(expo(32'h0000_0000)));
        chk(32'(aux_clr), 32'h0000_0000);
        host.frame(8'h80, 32'h0000_0000, 1'b0, q);
        chk(q, 32'h0000_0000);
        sync_chk();
    endtask : t_reset

    task automatic t_fields;
        // open bits 31:29, 25:24 and 18:17 stay zero in every word
        logic [31:0] tbl [6] = '{32'h0400_0000, 32'h0001_4000, 32'h0850_0000,
                                  32'h0050_0000, 32'h1000_2AAA, 32'h0008_0000};
        for (int s = 0; s < 2; s++) begin
            sweep = s[0];
            pins = s[0] ? 3'h5 : 3'h3;
            foreach (tbl[i]) begin
                apply(tbl[i]);
                sync_chk();
            end
        end
    endtask : t_fields

    task automatic t_addr;
        logic [31:0] q;
        host.frame(8'h01, 32'hFFFF_FFFF, lsb_mode, q);
        host.frame(8'h80, 32'h0000_0000, lsb_mode, q);
        chk(q, act_w);
    endtask : t_addr

    task automatic t_aux(input logic v);
        int n;
        apply({16'h0000, v, 15'h0000});
        for (n = 0; n < 2 * SH + 3 && aux_clr !== v; n++) @(negedge clk);
        chk(32'(aux_clr), 32'(v));
        repeat (20) @(negedge clk);
        chk(32'(aux_clr), 32'(v));
    endtask : t_aux

    task automatic t_lsb;
        apply(32'h0080_0000);
        apply(32'h0080_A5C3);
        apply(32'h0000_0000);
    endtask : t_lsb

    // whole run needs roughly 9300 clocks
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_reset();
        t_fields();
        t_addr();
        t_aux(1'b1);
        t_aux(1'b0);
        t_lsb();
        final_report();
    end
endmodule : tb_top
